// [rtl/cas_device.sv]
// device end: configuration access port and status outputs
`timescale 1ns/1ps
`default_nettype none
module cas_device
  import cas_pkg::*;
#(
  parameter int STORE_DW = 64,
  parameter bit ROOT_PORT = 1'b0
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // user-facing carrier
  cas_if.dev link,
  // link layer state from the core
  input wire logic rx_detected_in,
  input wire logic link_established_flag_in,
  input wire logic dl_init_done_in,
  input wire logic [2:0] width_in,
  input wire logic [1:0] speed_in,
  input wire logic [5:0] ltssm_in,
  input wire logic [1:0] rx_substate_in,
  // power requests seen on the link
  input wire logic partner_l1_req_in,
  input wire logic tx_idle_in,
  input wire logic l23_ready_in,
  // error events, bit n raises code n
  input wire logic [CAS_ERR_LAST:1] err_event_in,
  // power decisions
  output logic l1_refused_out,
  output logic tx_standby_out
);

  localparam int IDX_W = $clog2(CAS_PF_NUM * STORE_DW);
  localparam int DW_W = $clog2(STORE_DW);

  // parameter checks
  if (STORE_DW <= 32'(CAS_DEVCTL_DW) || STORE_DW > 1024)
    $error("cas_device: STORE_DW must hold control dwords, max 1024");
  if (CAS_PF_NUM != 4)
    $error("cas_device: exactly four physical functions supported");

  typedef enum logic {CAS_ST_IDLE, CAS_ST_GAP} cas_acc_t;

  // byte-lane merge, enable n covers bits 8n+7..8n
  function automatic logic [31:0] cas_merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (be[b] && msk[8*b+i])
          res[8*b+i] = new_v[8*b+i];
      end
    end
    return res;
  endfunction

  // writable bits of a dword; on a root port, debug opens type-1 read-only fields
  function automatic logic [31:0] cas_wmask(input logic [9:0] a,
    input logic dbg);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    if (ROOT_PORT && dbg && a < CAS_TYPE1_END_DW)
      m = 32'hFFFF_FFFF;
    else if (a == CAS_ID_DW || a == CAS_CLASS_DW)
      m = 32'h0000_0000;
    return m;
  endfunction

  // power state field and command bits to reported power code
  function automatic logic [2:0] cas_pwr(input logic [1:0] ps,
    input logic cfgd);
    logic [2:0] c;
    c = CAS_PWR_D1;
    if (ps == 2'h0)
      c = cfgd ? CAS_PWR_D0_ACTIVE : CAS_FULL_POWER_UNCONFIGURED;
    else if (ps == 2'h3)
      c = CAS_POWERED_OFF_HOT;
    return c;
  endfunction

  // priority of each error code, 0 ranks highest
  function automatic logic [4:0] cas_pri(input int c);
    logic [4:0] p;
    case (c)
      1: p = 5'h10;
      2: p = 5'h0C;
      3: p = 5'h0D;
      4: p = 5'h0A;
      5: p = 5'h0B;
      6: p = 5'h09;
      7: p = 5'h03;
      8: p = 5'h03;
      9: p = 5'h14;
      10: p = 5'h01;
      11: p = 5'h15;
      12: p = 5'h02;
      13: p = 5'h05;
      14: p = 5'h06;
      15: p = 5'h07;
      16: p = 5'h08;
      17: p = 5'h04;
      18: p = 5'h0F;
      19: p = 5'h0E;
      20: p = 5'h11;
      21: p = 5'h12;
      22: p = 5'h13;
      23: p = 5'h00;
      default: p = CAS_PRI_NONE;
    endcase
    return p;
  endfunction

  // pick the highest-priority pending error, lower code on a tie
  function automatic logic [4:0] cas_best(
    input logic [CAS_ERR_LAST:1] ev);
    logic [4:0] code;
    logic [4:0] best;
    code = CAS_ERR_NONE;
    best = CAS_PRI_NONE;
    for (int c = 1; c <= CAS_ERR_LAST; c++)
    begin
      if (ev[c] && cas_pri(c) < best)
      begin
        best = cas_pri(c);
        code = 5'(c);
      end
    end
    return code;
  endfunction

  cas_acc_t state_r;
  logic [31:0] cfg_mem [CAS_PF_NUM*STORE_DW];
  logic [CAS_VF_NUM-1:0] vf_en_r;
  logic [CAS_VF_NUM-1:0] vf_bme_r;
  logic [1:0] vf_ps_r [CAS_VF_NUM];
  logic acc_go;
  logic wr_go;
  logic is_pf;
  logic is_vf;
  logic in_store;
  logic [7:0] vf_idx;
  logic [IDX_W-1:0] mem_idx;
  logic [31:0] rd_val;
  logic [31:0] wr_val;

  // request decode
  assign acc_go = state_r == CAS_ST_IDLE
    && (link.mgmt_read || link.mgmt_write);
  assign wr_go = acc_go && link.mgmt_write;
  assign is_pf = link.mgmt_func < 8'(CAS_PF_NUM);
  assign vf_idx = link.mgmt_func - 8'(CAS_PF_NUM);
  assign is_vf = !is_pf && vf_idx < 8'(CAS_VF_NUM);
  assign in_store = link.mgmt_addr < 10'(STORE_DW);
  assign mem_idx = IDX_W'({link.mgmt_func[1:0], link.mgmt_addr[DW_W-1:0]});
  assign wr_val = cas_merge(cfg_mem[mem_idx], link.mgmt_wdata,
    link.mgmt_be, cas_wmask(link.mgmt_addr, link.mgmt_debug));

  // read value for the addressed function
  always_comb
  begin
    rd_val = CAS_WORD_RST;
    if (is_pf && in_store)
      rd_val = cfg_mem[mem_idx];
    else if (is_vf && link.mgmt_addr == CAS_CMD_DW)
      rd_val = {29'h0, vf_bme_r[vf_idx], vf_en_r[vf_idx], 1'b0};
    else if (is_vf && link.mgmt_addr == CAS_PMCSR_DW)
      rd_val = {30'h0, vf_ps_r[vf_idx]};
  end

  // access sequencing: one access, done pulse, one idle gap
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_r <= CAS_ST_IDLE;
      link.mgmt_done <= 1'b0;
      link.mgmt_rdata <= CAS_WORD_RST;
    end
    else
    begin
      case (state_r)
        CAS_ST_IDLE:
        begin
          if (acc_go)
          begin
            state_r <= CAS_ST_GAP;
            link.mgmt_done <= 1'b1;
            link.mgmt_rdata <= link.mgmt_write ? CAS_WORD_RST : rd_val;
          end
        end
        CAS_ST_GAP:
        begin
          state_r <= CAS_ST_IDLE;
          link.mgmt_done <= 1'b0;
        end
        default: state_r <= CAS_ST_IDLE;
      endcase
    end
  end

  // physical function configuration store
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < CAS_PF_NUM * STORE_DW; i++)
        cfg_mem[i] <= CAS_WORD_RST;
    end
    else if (wr_go && is_pf && in_store)
      cfg_mem[mem_idx] <= wr_val;
  end

  // virtual function command and power bits
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      vf_en_r <= '0;
      vf_bme_r <= '0;
      for (int v = 0; v < CAS_VF_NUM; v++)
        vf_ps_r[v] <= CAS_PS_RST;
    end
    else if (wr_go && is_vf && link.mgmt_addr == CAS_CMD_DW
      && link.mgmt_be[0])
    begin
      vf_en_r[vf_idx] <= link.mgmt_wdata[CAS_CMD_MEM_BIT];
      vf_bme_r[vf_idx] <= link.mgmt_wdata[CAS_CMD_BME_BIT];
    end
    else if (wr_go && is_vf && link.mgmt_addr == CAS_PMCSR_DW
      && link.mgmt_be[0])
      vf_ps_r[vf_idx] <= link.mgmt_wdata[CAS_PS_LSB +: 2];
  end

  // function status and power vectors
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      link.func_status <= '0;
      link.func_power <= '0;
      link.vf_enable_bits <= '0;
      link.vf_device_power <= '0;
      link.max_payload <= 2'h0;
      link.max_read_req <= 3'h0;
    end
    else
    begin
      for (int f = 0; f < CAS_PF_NUM; f++)
      begin
        link.func_status[4*f+:4] <= {
          cfg_mem[f*STORE_DW+1][CAS_CMD_INTX_BIT],
          cfg_mem[f*STORE_DW+1][CAS_CMD_BME_BIT],
          cfg_mem[f*STORE_DW+1][CAS_CMD_MEM_BIT],
          cfg_mem[f*STORE_DW+1][CAS_CMD_IO_BIT]};
        link.func_power[3*f+:3] <= cas_pwr(
          cfg_mem[f*STORE_DW+17][CAS_PS_LSB+:2],
          cfg_mem[f*STORE_DW+1][CAS_CMD_MEM_BIT]
          | cfg_mem[f*STORE_DW+1][CAS_CMD_IO_BIT]);
      end
      for (int v = 0; v < CAS_VF_NUM; v++)
      begin
        link.vf_enable_bits[2*v+:2] <= {vf_bme_r[v], vf_en_r[v]};
        link.vf_device_power[3*v+:3] <= cas_pwr(vf_ps_r[v],
          vf_en_r[v]);
      end
      link.max_payload <= cfg_mem[18][CAS_MPS_LSB+:2];
      link.max_read_req <= cfg_mem[18][CAS_MRRS_LSB+:3];
    end
  end

  // link state reporting
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      link.link_down <= 1'b0;
      link.link_status <= CAS_LS_NO_RX;
      link.neg_width <= 3'h0;
      link.cur_speed <= 2'h0;
      link.ltssm_state <= 6'h00;
      link.rx_standby_substate <= CAS_RX_NOT_STANDBY;
    end
    else
    begin
      link.link_down <= !link_established_flag_in;
      if (!rx_detected_in)
        link.link_status <= CAS_LS_NO_RX;
      else if (!link_established_flag_in)
        link.link_status <= CAS_LS_TRAIN;
      else if (!dl_init_done_in)
        link.link_status <= CAS_LS_DL_INIT;
      else
        link.link_status <= CAS_LS_UP;
      link.neg_width <= width_in;
      link.cur_speed <= speed_in;
      link.ltssm_state <= ltssm_in;
      link.rx_standby_substate <= ltssm_in == CAS_LTSSM_L0
        ? rx_substate_in : CAS_RX_NOT_STANDBY;
    end
  end

  // link power decisions under user restrictions
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      link.link_power <= CAS_LP_L0;
      l1_refused_out <= 1'b0;
      tx_standby_out <= 1'b0;
    end
    else
    begin
      l1_refused_out <= partner_l1_req_in && ROOT_PORT
        && link.l1_request_refuse;
      tx_standby_out <= tx_idle_in && !link.tx_standby_block;
      if (!dl_init_done_in)
        link.link_power <= CAS_LP_L0;
      else if (l23_ready_in)
        link.link_power <= CAS_LP_L23;
      else if (partner_l1_req_in
        && !(ROOT_PORT && link.l1_request_refuse))
        link.link_power <= CAS_LP_L1;
      else if (tx_idle_in && !link.tx_standby_block)
        link.link_power <= CAS_LP_TX_L0S;
      else
        link.link_power <= CAS_LP_L0;
    end
  end

  // local error reporting
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      link.err_valid <= 1'b0;
      link.err_code <= CAS_ERR_NONE;
    end
    else
    begin
      link.err_valid <= |err_event_in;
      link.err_code <= cas_best(err_event_in);
    end
  end

endmodule // cas_device
`default_nettype wire

// [rtl/cas_if.sv]
// signals between the device end and the user end
`timescale 1ns/1ps
`default_nettype none
interface cas_if;
  import cas_pkg::*;
  // power management requests from user
  logic l1_request_refuse;
  logic tx_standby_block;
  // configuration access
  logic [9:0] mgmt_addr;
  logic [7:0] mgmt_func;
  logic mgmt_write;
  logic mgmt_read;
  logic [31:0] mgmt_wdata;
  logic [3:0] mgmt_be;
  logic mgmt_debug;
  logic [31:0] mgmt_rdata;
  logic mgmt_done;
  // status
  logic link_down;
  logic [1:0] link_status;
  logic [2:0] neg_width;
  logic [1:0] cur_speed;
  logic [1:0] max_payload;
  logic [2:0] max_read_req;
  logic [CAS_FS_W-1:0] func_status;
  logic [CAS_VFS_W-1:0] vf_enable_bits;
  logic [CAS_PFP_W-1:0] func_power;
  logic [CAS_VFP_W-1:0] vf_device_power;
  logic [1:0] link_power;
  logic [4:0] err_code;
  logic err_valid;
  logic [1:0] rx_standby_substate;
  logic [5:0] ltssm_state;

  modport dev (
    input l1_request_refuse, tx_standby_block, mgmt_addr, mgmt_func,
    input mgmt_write, mgmt_read, mgmt_wdata, mgmt_be, mgmt_debug,
    output mgmt_rdata, mgmt_done, link_down, link_status, neg_width,
    output cur_speed, max_payload, max_read_req, func_status,
    output vf_enable_bits, func_power, vf_device_power, link_power,
    output err_code, err_valid, rx_standby_substate, ltssm_state
  );

  modport usr (
    output l1_request_refuse, tx_standby_block, mgmt_addr, mgmt_func,
    output mgmt_write, mgmt_read, mgmt_wdata, mgmt_be, mgmt_debug,
    input mgmt_rdata, mgmt_done, link_down, link_status, neg_width,
    input cur_speed, max_payload, max_read_req, func_status,
    input vf_enable_bits, func_power, vf_device_power, link_power,
    input err_code, err_valid, rx_standby_substate, ltssm_state
  );
endinterface : cas_if
`default_nettype wire

// [rtl/cas_pkg.sv]
// constants shared by the configuration access and status ends
package cas_pkg;

  // function counts and vector widths
  localparam int CAS_PF_NUM = 4;
  localparam int CAS_VF_NUM = 252;
  localparam int CAS_FS_W = 4 * CAS_PF_NUM;
  localparam int CAS_VFS_W = 2 * CAS_VF_NUM;
  localparam int CAS_PFP_W = 3 * CAS_PF_NUM;
  localparam int CAS_VFP_W = 3 * CAS_VF_NUM;

  // configuration dword offsets
  localparam logic [9:0] CAS_ID_DW = 10'h000;
  localparam logic [9:0] CAS_CMD_DW = 10'h001;
  localparam logic [9:0] CAS_CLASS_DW = 10'h002;
  localparam logic [9:0] CAS_TYPE1_END_DW = 10'h010;
  localparam logic [9:0] CAS_PMCSR_DW = 10'h011;
  localparam logic [9:0] CAS_DEVCTL_DW = 10'h012;

  // field positions
  localparam int CAS_CMD_IO_BIT = 0;
  localparam int CAS_CMD_MEM_BIT = 1;
  localparam int CAS_CMD_BME_BIT = 2;
  localparam int CAS_CMD_INTX_BIT = 10;
  localparam int CAS_MPS_LSB = 5;
  localparam int CAS_MRRS_LSB = 12;
  localparam int CAS_PS_LSB = 0;

  // reset values
  localparam logic [31:0] CAS_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] CAS_PS_RST = 2'h0;

  // link status, power, ltssm and rx substate codes
  localparam logic [1:0] CAS_LS_NO_RX = 2'h0;
  localparam logic [1:0] CAS_LS_TRAIN = 2'h1;
  localparam logic [1:0] CAS_LS_DL_INIT = 2'h2;
  localparam logic [1:0] CAS_LS_UP = 2'h3;
  localparam logic [1:0] CAS_LP_L0 = 2'h0;
  localparam logic [1:0] CAS_LP_TX_L0S = 2'h1;
  localparam logic [1:0] CAS_LP_L1 = 2'h2;
  localparam logic [1:0] CAS_LP_L23 = 2'h3;
  localparam logic [5:0] CAS_LTSSM_L0 = 6'h10;
  localparam logic [1:0] CAS_RX_NOT_STANDBY = 2'h0;

  // function power codes
  localparam logic [2:0] CAS_FULL_POWER_UNCONFIGURED = 3'h0;
  localparam logic [2:0] CAS_PWR_D0_ACTIVE = 3'h1;
  localparam logic [2:0] CAS_PWR_D1 = 3'h2;
  localparam logic [2:0] CAS_POWERED_OFF_HOT = 3'h4;

  // error codes and priorities
  localparam int CAS_ERR_LAST = 23;
  localparam logic [4:0] CAS_ERR_NONE = 5'h00;
  localparam logic [4:0] CAS_PRI_NONE = 5'h1F;

  // smallest payload and read size in bytes
  localparam logic [15:0] CAS_SIZE_BASE = 16'h0080;

endpackage : cas_pkg

// [rtl/cas_user.sv]
// user end: issues configuration accesses and sets power limits
`timescale 1ns/1ps
`default_nettype none
module cas_user
  import cas_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // device-facing carrier
  cas_if.usr link,
  // access command
  input wire logic cmd_read_in,
  input wire logic cmd_write_in,
  input wire logic cmd_debug_in,
  input wire logic [9:0] cmd_addr_in,
  input wire logic [7:0] cmd_func_in,
  input wire logic [31:0] cmd_wdata_in,
  input wire logic [3:0] cmd_be_in,
  // access answer
  output logic cmd_busy_out,
  output logic rsp_valid_out,
  output logic [31:0] rsp_data_out,
  // power restrictions
  input wire logic l1_refuse_in,
  input wire logic tx_block_in,
  // size limits in bytes
  output logic [15:0] payload_limit_out,
  output logic [15:0] read_limit_out
);

  // size code to byte count, 128 doubling
  function automatic logic [15:0] cas_bytes(input logic [2:0] code);
    return CAS_SIZE_BASE << code;
  endfunction

  // access issue, held steady until done
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cmd_busy_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= CAS_WORD_RST;
      link.mgmt_read <= 1'b0;
      link.mgmt_write <= 1'b0;
      link.mgmt_debug <= 1'b0;
      link.mgmt_addr <= 10'h000;
      link.mgmt_func <= 8'h00;
      link.mgmt_wdata <= CAS_WORD_RST;
      link.mgmt_be <= 4'h0;
    end
    else
    begin
      rsp_valid_out <= 1'b0;
      if (cmd_busy_out && link.mgmt_done)
      begin
        cmd_busy_out <= 1'b0;
        link.mgmt_read <= 1'b0;
        link.mgmt_write <= 1'b0;
        link.mgmt_debug <= 1'b0;
        rsp_valid_out <= 1'b1;
        rsp_data_out <= link.mgmt_rdata;
      end
      else if (!cmd_busy_out && (cmd_read_in || cmd_write_in))
      begin
        cmd_busy_out <= 1'b1;
        link.mgmt_write <= cmd_write_in;
        link.mgmt_read <= !cmd_write_in;
        link.mgmt_debug <= cmd_debug_in && cmd_write_in;
        link.mgmt_addr <= cmd_addr_in;
        link.mgmt_func <= cmd_func_in;
        link.mgmt_wdata <= cmd_wdata_in;
        link.mgmt_be <= cmd_be_in;
      end
    end
  end

  // power restrictions and size limits
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      link.l1_request_refuse <= 1'b0;
      link.tx_standby_block <= 1'b0;
      payload_limit_out <= CAS_SIZE_BASE;
      read_limit_out <= CAS_SIZE_BASE;
    end
    else
    begin
      link.l1_request_refuse <= l1_refuse_in;
      link.tx_standby_block <= tx_block_in;
      payload_limit_out <= cas_bytes({1'b0, link.max_payload});
      read_limit_out <= cas_bytes(link.max_read_req);
    end
  end

endmodule // cas_user
`default_nettype wire

// [verif/cas_link_sva.sv]
// assertions watching the link between the device end and the user end
`timescale 1ns/1ps
`default_nettype none
module cas_link_sva
  import cas_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // access signals
  input wire logic mgmt_read,
  input wire logic mgmt_write,
  input wire logic [9:0] mgmt_addr,
  input wire logic [7:0] mgmt_func,
  input wire logic [31:0] mgmt_wdata,
  input wire logic [3:0] mgmt_be,
  input wire logic mgmt_done,
  // status signals
  input wire logic link_down,
  input wire logic [1:0] link_status,
  input wire logic [1:0] link_power,
  input wire logic err_valid,
  input wire logic [4:0] err_code,
  input wire logic [1:0] rx_standby_substate,
  input wire logic [5:0] ltssm_state
);
  // all checks share the system clock; all but reset_low_a share its reset
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  // access handshake
  done_pulse_a: assert property (
    mgmt_done |=> !mgmt_done) else $error("done wider than one cycle");
  done_follows_a: assert property (
    $rose(mgmt_read || mgmt_write) |=> mgmt_done)
    else $error("done missing after request");
  done_cause_a: assert property (
    mgmt_done |-> $past(mgmt_read || mgmt_write))
    else $error("done without request");
  req_hold_a: assert property (
    (mgmt_read || mgmt_write) && !mgmt_done |=> $stable({mgmt_read,
    mgmt_write, mgmt_addr, mgmt_func, mgmt_wdata, mgmt_be}))
    else $error("request changed before done");
  one_strobe_a: assert property (
    !(mgmt_read && mgmt_write)) else $error("read and write together");
  strobe_drop_a: assert property (
    mgmt_done |=> !(mgmt_read || mgmt_write))
    else $error("request held after done");
  // status relations
  reset_low_a: assert property (
    disable iff (1'b0) $past(rst_in) |-> !link_down)
    else $error("link down high in reset");
  training_down_a: assert property (
    link_status == CAS_LS_TRAIN |-> link_down)
    else $error("link down low while training");
  up_not_down_a: assert property (
    link_status[1] |-> !link_down) else $error("link down while up");
  power_idle_a: assert property (
    link_status == CAS_LS_DL_INIT |-> link_power == CAS_LP_L0)
    else $error("link power not L0 before init");
  err_code_a: assert property (
    err_valid |-> err_code != CAS_ERR_NONE && err_code <= 5'h17)
    else $error("error code out of range");
  rx_idle_a: assert property (
    ltssm_state != CAS_LTSSM_L0 |-> rx_standby_substate == 2'h0)
    else $error("rx substate set outside L0");
endmodule // cas_link_sva
`default_nettype wire

// [verif/config_access_and_status_ports_bench.sv]
// self-checking bench joining the device end and the user end
`timescale 1ns/1ps
`default_nettype none
module config_access_and_status_ports_bench;
  import cas_pkg::*;
  // expected answer and the bits that matter in it
  typedef struct {logic [31:0] d; logic [31:0] m;} cas_exp_t;
  logic clk_sys_in;
  logic rst_in;
  logic rx_det, lnk_up, dl_done, l1_req, tx_idle, l23;
  logic [2:0] width;
  logic [1:0] speed, rx_sub;
  logic [5:0] ltssm;
  logic [CAS_ERR_LAST:1] err_ev, ev;
  logic l1_refused, tx_standby, cmd_busy, rsp_valid;
  logic cmd_read, cmd_write, cmd_debug, l1_refuse, tx_block;
  logic [9:0] cmd_addr;
  logic [7:0] cmd_func;
  logic [31:0] cmd_wdata, rsp_data, r;
  logic [3:0] cmd_be;
  logic [15:0] payload_limit, read_limit;
  logic [2:0] pw [4];
  logic [8:0] pm [5];
  cas_exp_t exp_q[$];
  cas_exp_t e;
  int err_total, n_tests, seed, i, k;

  // the two ends and the checker on their link
  cas_if bus ();
  cas_device #(.STORE_DW(64), .ROOT_PORT(1'b1)) cas_device_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(bus),
    .rx_detected_in(rx_det), .link_established_flag_in(lnk_up),
    .dl_init_done_in(dl_done), .width_in(width), .speed_in(speed),
    .ltssm_in(ltssm), .rx_substate_in(rx_sub), .partner_l1_req_in(l1_req),
    .tx_idle_in(tx_idle), .l23_ready_in(l23), .err_event_in(err_ev),
    .l1_refused_out(l1_refused), .tx_standby_out(tx_standby));
  cas_user cas_user_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(bus),
    .cmd_read_in(cmd_read), .cmd_write_in(cmd_write),
    .cmd_debug_in(cmd_debug), .cmd_addr_in(cmd_addr),
    .cmd_func_in(cmd_func), .cmd_wdata_in(cmd_wdata), .cmd_be_in(cmd_be),
    .cmd_busy_out(cmd_busy), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .l1_refuse_in(l1_refuse),
    .tx_block_in(tx_block), .payload_limit_out(payload_limit),
    .read_limit_out(read_limit));
  cas_link_sva cas_link_sva_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .mgmt_read(bus.mgmt_read), .mgmt_write(bus.mgmt_write),
    .mgmt_addr(bus.mgmt_addr), .mgmt_func(bus.mgmt_func),
    .mgmt_wdata(bus.mgmt_wdata), .mgmt_be(bus.mgmt_be),
    .mgmt_done(bus.mgmt_done), .link_down(bus.link_down),
    .link_status(bus.link_status), .link_power(bus.link_power),
    .err_valid(bus.err_valid), .err_code(bus.err_code),
    .rx_standby_substate(bus.rx_standby_substate),
    .ltssm_state(bus.ltssm_state));

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  // print counts and verdict, then stop
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // let status inputs travel through both ends
  task automatic settle;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  // one access; a second request while busy must be ignored
  task automatic acc(input logic wr, input logic dbg, input logic [9:0] a,
    input logic [7:0] f, input logic [31:0] d, input logic [31:0] m,
    input logic [3:0] be);
    int n;
    @(posedge clk_sys_in);
    cmd_read <= !wr;
    cmd_write <= wr;
    cmd_debug <= dbg;
    cmd_addr <= a;
    cmd_func <= f;
    cmd_wdata <= d;
    cmd_be <= be;
    exp_q.push_back('{wr ? 32'h0 : d, wr ? 32'hFFFF_FFFF : m});
    @(posedge clk_sys_in);
    cmd_read <= 1'b0;
    cmd_write <= 1'b0;
    @(posedge clk_sys_in);
    cmd_read <= 1'b1;
    @(posedge clk_sys_in);
    cmd_read <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_sys_in);
      n++;
    end
    while (cmd_busy !== 1'b0 && n < 20);
  endtask

  // answer watcher: oldest note against each answer
  always @(posedge clk_sys_in)
  begin
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare answer", 32'h1, 32'h0);
      else
      begin
        e = exp_q.pop_front();
        chk("answer", e.d & e.m, rsp_data & e.m);
      end
    end
  end

  // clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // watchdog
  initial
  begin
    repeat (8000) @(posedge clk_sys_in);
    err_total++;
    results();
  end

  // main sequence
  initial
  begin
    seed = 79;
    {rx_det, lnk_up, dl_done, l1_req, tx_idle, l23} = '0;
    {cmd_read, cmd_write, cmd_debug, l1_refuse, tx_block} = '0;
    {width, speed, rx_sub, ltssm, err_ev} = '0;
    {cmd_addr, cmd_func, cmd_wdata, cmd_be} = '0;
    pw = '{CAS_PWR_D0_ACTIVE, CAS_PWR_D1, CAS_PWR_D1, CAS_POWERED_OFF_HOT};
    pm = '{9'h188, 9'h102, 9'h060, 9'h045, 9'h013};
    rst_in = 1'b1;
    repeat (19) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("link down in reset", 32'h0, 32'(bus.link_down));
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_sys_in);
      {rx_det, lnk_up, dl_done} <= 3'(i);
      width <= 3'($unsigned($random(seed)) % 5);
      speed <= 2'($unsigned($random(seed)) % 3);
      settle();
      k = !rx_det ? 0 : !lnk_up ? 1 : !dl_done ? 2 : 3;
      chk("link status", k, 32'(bus.link_status));
      chk("link down", 32'(!lnk_up), 32'(bus.link_down));
      if (k == 3) chk("width", 32'(width), 32'(bus.neg_width));
      chk("speed", 32'(speed), 32'(bus.cur_speed));
    end
    k = $unsigned($random(seed)) % CAS_PF_NUM;
    acc(1'b1, 1'b0, CAS_CMD_DW, 8'(k), 32'hFFFF_FFFF, 0, 4'hF);
    acc(1'b1, 1'b0, CAS_CMD_DW, 8'(k), 32'h0, 0, 4'hE);
    acc(1'b0, 1'b0, CAS_CMD_DW, 8'(k), 32'h7, 32'h407, 4'h0);
    chk("function status", 4'h7, 32'(bus.func_status[4*k +: 4]));
    chk("idle power", 0, 32'(bus.func_power[3*((k+1)%4) +: 3]));
    for (i = 0; i < 4; i++)
    begin
      acc(1'b1, 1'b0, CAS_PMCSR_DW, 8'(k), 32'(i), 0, 4'hF);
      settle();
      chk("function power", 32'(pw[i]), 32'(bus.func_power[3*k +: 3]));
    end
    for (i = 0; i < 6; i++)
    begin
      r = (32'(i) << 12) | (32'(i % 4) << 5);
      acc(1'b1, 1'b0, CAS_DEVCTL_DW, 8'h0, r, 0, 4'hF);
      acc(1'b0, 1'b0, CAS_DEVCTL_DW, 8'h0, r, 32'h7060, 4'h0);
      settle();
      chk("payload code", i % 4, 32'(bus.max_payload));
      chk("read code", i, 32'(bus.max_read_req));
      chk("payload bytes", 128 << (i % 4), 32'(payload_limit));
      chk("read bytes", 128 << i, 32'(read_limit));
    end
    k = $unsigned($random(seed)) % CAS_VF_NUM;
    acc(1'b1, 1'b0, CAS_CMD_DW, 8'(k + 4), 32'h2, 0, 4'h1);
    settle();
    chk("vf bits", 2'b01, 32'(bus.vf_enable_bits[2*k +: 2]));
    acc(1'b1, 1'b0, CAS_CMD_DW, 8'(k + 4), 32'h6, 0, 4'h1);
    acc(1'b1, 1'b0, CAS_PMCSR_DW, 8'(k + 4), 32'h3, 0, 4'hF);
    settle();
    chk("vf bits", 2'b11, 32'(bus.vf_enable_bits[2*k +: 2]));
    chk("vf power", 3'h4, 32'(bus.vf_device_power[3*k +: 3]));
    r = $random(seed);
    acc(1'b1, 1'b0, CAS_ID_DW, 8'h0, r, 0, 4'hF);
    acc(1'b0, 1'b0, CAS_ID_DW, 8'h0, CAS_WORD_RST, '1, 4'h0);
    acc(1'b1, 1'b1, CAS_ID_DW, 8'h0, r, 0, 4'hF);
    acc(1'b0, 1'b0, CAS_ID_DW, 8'h0, r, '1, 4'h0);
    acc(1'b0, 1'b0, 10'h3FF, 8'h0, 32'h0, '1, 4'h0);
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk_sys_in);
      {l1_req, l1_refuse, tx_idle, tx_block, l23} <= pm[i][8:4];
      settle();
      chk("power outputs", 32'(pm[i][3:0]), 32'({l1_refused, tx_standby,
        bus.link_power}));
    end
    for (i = 0; i < 3; i++)
    begin
      k = i == 0 ? 7 : i == 1 ? 23 : 1 + $unsigned($random(seed)) % 23;
      ev = '0;
      ev[k] = 1'b1;
      ev[8] = ev[8] | (i == 0);
      ev[1] = ev[1] | (i == 1);
      @(posedge clk_sys_in);
      err_ev <= ev;
      @(posedge clk_sys_in);
      err_ev <= '0;
      @(negedge clk_sys_in);
      chk("error valid", 1, 32'(bus.err_valid));
      chk("error code", k, 32'(bus.err_code));
      @(negedge clk_sys_in);
      chk("error valid end", 0, 32'(bus.err_valid));
    end
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk_sys_in);
      ltssm <= i < 4 ? CAS_LTSSM_L0 : 6'h11;
      rx_sub <= 2'(i);
      settle();
      chk("link state", 32'(ltssm), 32'(bus.ltssm_state));
      chk("rx substate", i % 4, 32'(bus.rx_standby_substate));
    end
    repeat (5) @(posedge clk_sys_in);
    chk("answers left", 0, exp_q.size());
    results();
  end
endmodule // config_access_and_status_ports_bench
`default_nettype wire
